// ===== inc/fan_cfg_pkg.sv
/*
  constants of the fan auto-control configuration register bank:
  register offsets, field positions, reset values and code steps.
  assumes nothing of its surroundings.
*/
package fan_cfg_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] LOCAL_OFS_ADDR   = 8'h0D;
  localparam logic [7:0] REMOTE1_OFS_ADDR = 8'h0E;
  localparam logic [7:0] LOCAL_FSS_ADDR   = 8'h24;
  localparam logic [7:0] REMOTE1_FSS_ADDR = 8'h25;
  localparam logic [7:0] REMOTE2_FSS_ADDR = 8'h26;
  localparam logic [7:0] ALERT_REV_ADDR   = 8'h3F;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] LOCAL_FSS_RST  = 8'h41;
  localparam logic [7:0] REMOTE_FSS_RST = 8'h61;
  localparam logic [7:0] OFS_RST        = 8'h00;
  localparam logic       FULL_EN_RST    = 1'h1;
  localparam logic [3:0] MIN_SPEED_RST  = 4'h5;

  // ************************************************************
  // field positions and code steps
  // ************************************************************
  localparam int START_MSB   = 7;
  localparam int START_LSB   = 3;
  localparam int SPAN_MSB    = 2;
  localparam int SPAN_LSB    = 0;
  localparam int FULL_EN_BIT = 7;
  localparam int REV_MSB     = 3;
  localparam int SIGN_BIT    = 7;
  localparam int MAG_MSB     = 3;
  localparam int START_SHIFT = 2;            // 4 degrees per code step
  localparam logic [3:0] DUTY_FULL = 4'hF;

  typedef enum logic [2:0] {
    SPAN_5  = 3'b000,
    SPAN_10 = 3'b001,
    SPAN_20 = 3'b010,
    SPAN_40 = 3'b011,
    SPAN_80 = 3'b100
  } span_e;
endpackage

// ===== hdl/fan_auto_temp_config_regs.sv
/*
  configuration register bank for automatic fan control: fan start
  temperature and control span per channel, alert full-speed enable,
  revision nibble, reading offsets, plus the duty ramp they steer.
  assumes the management-bus slave sits on ref_clk_i and presents a
  one-cycle read or write strobe with an 8-bit register address; the
  readings and minimum-speed nibbles come from logic on the same clock.
*/
// How it works
// - start field bits 7:3, 4 C per code
// - codes 11110/11111 give 120/124 C
// - span codes 5,10,20,40,80 C; reset 10
// - local start/span resets to 0x41
// - remote start/span registers reset to 0x61
// - each channel ramps from its own set
// - enabled alert low forces full speed; reset 1
// - revision nibble read only, writes ignored
// - sign bit 7: 0 adds, 1 subtracts
// - magnitude bits 3:0, 0 to 15 C
// - remote1 bits 6:4 read zero; offsets reset 0
// - normal-speed nibble is the minimum duty
`timescale 1ns/1ps
`default_nettype none
module fan_auto_temp_config_regs #(
  parameter logic [3:0] REVISION = 4'h3    // arbitrary value
) (
  // clock and reset
  input  wire  logic              ref_clk_i,
  input  wire  logic              nrst_i,
  // register port from the management-bus slave
  input  wire  logic [7:0]        reg_addr_i,
  input  wire  logic              reg_wr_i,
  input  wire  logic              reg_rd_i,
  input  wire  logic [7:0]        reg_wdata_i,
  output logic [7:0]              reg_rdata_o,
  // raw readings, signed whole degrees
  input  wire  logic signed [7:0] local_temp_i,
  input  wire  logic signed [7:0] remote1_temp_i,
  input  wire  logic signed [7:0] remote2_temp_i,
  // minimum speed nibbles of fan 1 and fan 2
  input  wire  logic [3:0]        fan1_min_speed_i,
  input  wire  logic [3:0]        fan2_min_speed_i,
  // over-temperature alert pin, active low, asynchronous
  input  wire  logic              overtemp_alert_pin_n_i,
  // corrected readings
  output logic signed [7:0]       local_temp_o,
  output logic signed [7:0]       remote1_temp_o,
  // duty nibble demanded by each channel
  output logic [3:0]              local_duty_o,
  output logic [3:0]              remote1_duty_o,
  output logic [3:0]              remote2_duty_o,
  output logic                    full_speed_o
);
  // ************************************************************
  // functions
  // ************************************************************
  // apply sign-magnitude offset, saturating to the signed range
  function automatic logic signed [7:0] apply_ofs(input logic signed [7:0] t,
                                                  input logic [7:0] ofs);
    logic signed [9:0] s;
    s = 10'(t);
    if (ofs[fan_cfg_pkg::SIGN_BIT]) begin
      s = s - 10'(ofs[fan_cfg_pkg::MAG_MSB:0]);
    end else begin
      s = s + 10'(ofs[fan_cfg_pkg::MAG_MSB:0]);
    end
    if (s > 10'sd127) begin
      apply_ofs = 8'sh7F;
    end else if (s < -10'sd128) begin
      apply_ofs = 8'sh80;
    end else begin
      apply_ofs = s[7:0];
    end
  endfunction

  // duty for one channel from its own start/span register
  function automatic logic [3:0] ramp(input logic signed [7:0] t,
                                      input logic [7:0] fss,
                                      input logic [3:0] min_spd);
    logic signed [9:0] diff;
    logic [10:0]       prod;
    logic [10:0]       step;
    logic [4:0]        code;
    code = fss[fan_cfg_pkg::START_MSB:fan_cfg_pkg::START_LSB];
    // code n means 4n degrees, all 32 codes up to 124
    diff = 10'(t) - 10'({code, 2'b00});
    prod = 11'(diff[7:0]) * 11'(fan_cfg_pkg::DUTY_FULL - min_spd);
    case (fss[fan_cfg_pkg::SPAN_MSB:fan_cfg_pkg::SPAN_LSB])
      fan_cfg_pkg::SPAN_5:  step = prod / 11'd5;
      fan_cfg_pkg::SPAN_10: step = prod / 11'd10;
      fan_cfg_pkg::SPAN_20: step = prod / 11'd20;
      fan_cfg_pkg::SPAN_40: step = prod / 11'd40;
      // reserved codes behave as the widest span
      default:              step = prod / 11'd80;
    endcase
    if (diff <= 10'sd0) begin
      ramp = min_spd;
    end else if (diff > 10'sd127 || step >= 11'(fan_cfg_pkg::DUTY_FULL - min_spd)) begin
      ramp = fan_cfg_pkg::DUTY_FULL;
    end else begin
      ramp = min_spd + step[3:0];
    end
  endfunction

  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0] local_fss_r, local_fss_nxt;
  logic [7:0] rem1_fss_r,  rem1_fss_nxt;
  logic [7:0] rem2_fss_r,  rem2_fss_nxt;
  logic       full_en_r,   full_en_nxt;
  logic [7:0] local_ofs_r, local_ofs_nxt;
  logic [7:0] rem1_ofs_r,  rem1_ofs_nxt;
  logic [7:0] rdata_r,     rdata_nxt;

  always_comb begin
    local_fss_nxt = local_fss_r;
    rem1_fss_nxt  = rem1_fss_r;
    rem2_fss_nxt  = rem2_fss_r;
    full_en_nxt   = full_en_r;
    local_ofs_nxt = local_ofs_r;
    rem1_ofs_nxt  = rem1_ofs_r;
    if (reg_wr_i) begin
      case (reg_addr_i)
        fan_cfg_pkg::LOCAL_FSS_ADDR:   local_fss_nxt = reg_wdata_i;
        fan_cfg_pkg::REMOTE1_FSS_ADDR: rem1_fss_nxt  = reg_wdata_i;
        fan_cfg_pkg::REMOTE2_FSS_ADDR: rem2_fss_nxt  = reg_wdata_i;
        // only the enable bit is stored; revision bits drop
        fan_cfg_pkg::ALERT_REV_ADDR:   full_en_nxt   = reg_wdata_i[fan_cfg_pkg::FULL_EN_BIT];
        // unused bits 6:4 are never stored
        fan_cfg_pkg::LOCAL_OFS_ADDR:   local_ofs_nxt = reg_wdata_i & 8'h8F;
        fan_cfg_pkg::REMOTE1_OFS_ADDR: rem1_ofs_nxt  = reg_wdata_i & 8'h8F;
        default: ;
      endcase
    end
  end

  // read data held until the next read strobe
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_i) begin
      case (reg_addr_i)
        fan_cfg_pkg::LOCAL_FSS_ADDR:   rdata_nxt = local_fss_r;
        fan_cfg_pkg::REMOTE1_FSS_ADDR: rdata_nxt = rem1_fss_r;
        fan_cfg_pkg::REMOTE2_FSS_ADDR: rdata_nxt = rem2_fss_r;
        fan_cfg_pkg::ALERT_REV_ADDR:   rdata_nxt = {full_en_r, 3'h0, REVISION};
        fan_cfg_pkg::LOCAL_OFS_ADDR:   rdata_nxt = local_ofs_r;
        fan_cfg_pkg::REMOTE1_OFS_ADDR: rdata_nxt = rem1_ofs_r;
        default:                       rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      local_fss_r <= fan_cfg_pkg::LOCAL_FSS_RST;
      rem1_fss_r  <= fan_cfg_pkg::REMOTE_FSS_RST;
      rem2_fss_r  <= fan_cfg_pkg::REMOTE_FSS_RST;
      full_en_r   <= fan_cfg_pkg::FULL_EN_RST;
      local_ofs_r <= fan_cfg_pkg::OFS_RST;
      rem1_ofs_r  <= fan_cfg_pkg::OFS_RST;
      rdata_r     <= 8'h00;
    end else begin
      local_fss_r <= local_fss_nxt;
      rem1_fss_r  <= rem1_fss_nxt;
      rem2_fss_r  <= rem2_fss_nxt;
      full_en_r   <= full_en_nxt;
      local_ofs_r <= local_ofs_nxt;
      rem1_ofs_r  <= rem1_ofs_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ************************************************************
  // alert pin synchroniser
  // ************************************************************
  logic alert_n_meta_r, alert_n_meta_nxt;
  logic alert_n_sync_r, alert_n_sync_nxt;

  always_comb begin
    alert_n_meta_nxt = overtemp_alert_pin_n_i;
    alert_n_sync_nxt = alert_n_meta_r;
  end

  // pin idles high, so reset to the released level
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alert_n_meta_r <= 1'h1;
      alert_n_sync_r <= 1'h1;
    end else begin
      alert_n_meta_r <= alert_n_meta_nxt;
      alert_n_sync_r <= alert_n_sync_nxt;
    end
  end

  // ************************************************************
  // corrected readings and duty demand
  // ************************************************************
  logic signed [7:0] local_cor_nxt, local_cor_r;
  logic signed [7:0] rem1_cor_nxt,  rem1_cor_r;
  logic [3:0]        l_duty_nxt,    l_duty_r;
  logic [3:0]        r1_duty_nxt,   r1_duty_r;
  logic [3:0]        r2_duty_nxt,   r2_duty_r;
  logic              full_nxt,      full_r;

  always_comb begin
    local_cor_nxt = apply_ofs(local_temp_i, local_ofs_r);
    rem1_cor_nxt  = apply_ofs(remote1_temp_i, rem1_ofs_r);
    full_nxt      = full_en_r & ~alert_n_sync_r;
    // fan 1 follows the local channel, fan 2 the remote ones
    l_duty_nxt    = ramp(local_cor_nxt, local_fss_r, fan1_min_speed_i);
    r1_duty_nxt   = ramp(rem1_cor_nxt, rem1_fss_r, fan2_min_speed_i);
    r2_duty_nxt   = ramp(remote2_temp_i, rem2_fss_r, fan2_min_speed_i);
    if (full_nxt) begin
      l_duty_nxt  = fan_cfg_pkg::DUTY_FULL;
      r1_duty_nxt = fan_cfg_pkg::DUTY_FULL;
      r2_duty_nxt = fan_cfg_pkg::DUTY_FULL;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      local_cor_r <= 8'sh00;
      rem1_cor_r  <= 8'sh00;
      l_duty_r    <= fan_cfg_pkg::MIN_SPEED_RST;
      r1_duty_r   <= fan_cfg_pkg::MIN_SPEED_RST;
      r2_duty_r   <= fan_cfg_pkg::MIN_SPEED_RST;
      full_r      <= 1'h0;
    end else begin
      local_cor_r <= local_cor_nxt;
      rem1_cor_r  <= rem1_cor_nxt;
      l_duty_r    <= l_duty_nxt;
      r1_duty_r   <= r1_duty_nxt;
      r2_duty_r   <= r2_duty_nxt;
      full_r      <= full_nxt;
    end
  end

  assign local_temp_o   = local_cor_r;
  assign remote1_temp_o = rem1_cor_r;
  assign local_duty_o   = l_duty_r;
  assign remote1_duty_o = r1_duty_r;
  assign remote2_duty_o = r2_duty_r;
  assign full_speed_o   = full_r;
endmodule
`default_nettype wire

// ===== test/fan_auto_temp_config_regs_asserts.sv
/* port assertions of the fan config register bank.
   assumes inputs change only just after rising edges of ref_clk_i. */
`timescale 1ns/1ps
`default_nettype none
module fan_cfg_checker #(
  parameter logic [3:0] REVISION = 4'h3
) (
  // clock, reset and register port
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // fan side
  input wire logic [3:0] fan1_min_speed_i,
  input wire logic       overtemp_alert_pin_n_i,
  input wire logic [3:0] local_duty_o,
  input wire logic       full_speed_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence wr_fss_s;
    reg_wr_i && !reg_rd_i && reg_addr_i == fan_cfg_pkg::LOCAL_FSS_ADDR;
  endsequence
  sequence rd_fss_s;
    reg_rd_i && !reg_wr_i && reg_addr_i == fan_cfg_pkg::LOCAL_FSS_ADDR;
  endsequence
  // both offset registers, the remote one included
  sequence rd_ofs_s;
    reg_rd_i && (reg_addr_i == fan_cfg_pkg::LOCAL_OFS_ADDR ||
                 reg_addr_i == fan_cfg_pkg::REMOTE1_OFS_ADDR);
  endsequence
  // the host leaves one idle cycle between a write and the next strobe
  wr_rd_back_a: assert property (wr_fss_s ##1 !reg_wr_i ##1 rd_fss_s |=>
    reg_rdata_o == $past(reg_wdata_i, 3)) else $error("read-back mismatch");
  rev_nibble_a: assert property (reg_rd_i && reg_addr_i == 8'h3F |=>
    reg_rdata_o[3:0] == REVISION) else $error("revision nibble wrong");
  ofs_unused_a: assert property (rd_ofs_s |=> reg_rdata_o[6:4] == 3'h0)
    else $error("offset unused bits not zero");
  rd_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  full_rise_a: assert property ($rose(full_speed_o) |->
    !$past(overtemp_alert_pin_n_i, 3)) else $error("full speed without alert");
  full_drop_a: assert property (overtemp_alert_pin_n_i [*4] |-> !full_speed_o)
    else $error("full speed with alert released");
  full_duty_a: assert property (full_speed_o |-> local_duty_o == 4'hF)
    else $error("full speed but duty not full");
  min_floor_a: assert property (local_duty_o >= $past(fan1_min_speed_i))
    else $error("duty below minimum speed");
endmodule
bind fan_auto_temp_config_regs fan_cfg_checker #(.REVISION(REVISION)) i_fan_cfg_checker (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .fan1_min_speed_i(fan1_min_speed_i),
  .overtemp_alert_pin_n_i(overtemp_alert_pin_n_i),
  .local_duty_o(local_duty_o), .full_speed_o(full_speed_o));
`default_nettype wire

// ===== test/reg_host_model.sv
/* host side of the register strobe port.
   assumes strobes are sampled on the rising edge of ref_clk_i. */
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_wdata_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // callers keep span codes at 100 or below except to probe them
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    // idle lines show the inverse so stale data cannot pass
    reg_wdata_o <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== test/fan_auto_temp_config_regs_bench.sv
/* self-checking bench of the fan config register bank.
   assumes the host model is the only driver of the strobes. */
`timescale 1ns/1ps
`default_nettype none
module fan_auto_temp_config_regs_bench;
  localparam logic [3:0] REV = 4'hA; // arbitrary value
  logic clk, nrst_n, wr, rd, alert_n, full;
  logic [7:0] addr, wdata, rdata, d;
  logic signed [7:0] lt, r1t, r2t, lto, r1o;
  logic [3:0] ld, r1d, r2d;
  logic [3:0] m1, m2;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] ra [6] = '{8'h0D, 8'h0E, 8'h24, 8'h25, 8'h26, 8'h3F};
  logic [7:0] re [6] = '{8'h00, 8'h00, 8'h41, 8'h61, 8'h61, {4'h8, REV}};
  logic [3:0] se [6] = '{4'hF, 4'hA, 4'h7, 4'h6, 4'h5, 4'h5};
  logic [7:0] tf [4] = '{8'h41, 8'hF0, 8'hF8, 8'hF8};
  logic [7:0] tt [4] = '{8'd40, 8'd122, 8'd125, 8'd124};
  logic [3:0] te [4] = '{4'hD, 4'h9, 4'h7, 4'h5};
  fan_auto_temp_config_regs #(.REVISION(REV)) i_fan_auto_temp_config_regs (
    .ref_clk_i(clk), .nrst_i(nrst_n), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .local_temp_i(lt), .remote1_temp_i(r1t), .remote2_temp_i(r2t),
    .fan1_min_speed_i(m1), .fan2_min_speed_i(m2),
    .overtemp_alert_pin_n_i(alert_n), .local_temp_o(lto), .remote1_temp_o(r1o),
    .local_duty_o(ld), .remote1_duty_o(r1d), .remote2_duty_o(r2d),
    .full_speed_o(full));
  reg_host_model i_reg_host_model (.ref_clk_i(clk), .reg_rdata_i(rdata),
    .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 4000);
    bad_count++;
    end_of_test();
  end
  initial begin
    nrst_n = 1'b0;
    alert_n = 1'b1;
    lt = 8'sd0;
    r1t = 8'sd0;
    r2t = 8'sd5;
    m1 = 4'h5;
    m2 = 4'h5;
    repeat (16) @(posedge clk);
    nrst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      i_reg_host_model.rd_reg(ra[i], d);
      chk("reset value", re[i], d);
    end
    i_reg_host_model.rd_reg(8'h10, d);
    chk("unmapped read", 8'h00, d);
    $display("reset test done");
    // remote 2 at 5 C from a 0 C start, each span code in turn
    for (int i = 0; i < 6; i++) begin
      i_reg_host_model.wr_reg(8'h26, {5'h00, 3'(i)});
      settle();
      chk("span duty", {4'h0, se[i]}, {4'h0, r2d});
    end
    $display("span test done");
    for (int i = 0; i < 4; i++) begin
      i_reg_host_model.wr_reg(8'h24, tf[i]);
      @(posedge clk);
      lt <= tt[i];
      settle();
      chk("start duty", {4'h0, te[i]}, {4'h0, ld});
    end
    chk("remote one duty", 8'h05, {4'h0, r1d});
    $display("start test done");
    // local sits at its start point, remote 2 low in the widest span
    @(posedge clk);
    m1 <= 4'h9;
    m2 <= 4'h8;
    settle();
    chk("fan one minimum", 8'h09, {4'h0, ld});
    chk("fan two minimum", 8'h08, {4'h0, r1d});
    chk("remote two minimum", 8'h08, {4'h0, r2d});
    @(posedge clk);
    m1 <= 4'h5;
    m2 <= 4'h5;
    $display("minimum speed test done");
    i_reg_host_model.wr_reg(8'h3F, 8'h0F);
    i_reg_host_model.rd_reg(8'h3F, d);
    chk("alert and revision", {4'h0, REV}, d);
    i_reg_host_model.wr_reg(8'h0E, 8'hFF);
    i_reg_host_model.rd_reg(8'h0E, d);
    chk("remote one offset", 8'h8F, d);
    i_reg_host_model.wr_reg(8'h24, 8'h13);
    i_reg_host_model.rd_reg(8'h24, d);
    chk("start and span", 8'h13, d);
    $display("access test done");
    i_reg_host_model.wr_reg(8'h0D, 8'h85);
    @(posedge clk);
    lt <= 8'sd40;
    r1t <= 8'sd10;
    settle();
    chk("local minus offset", 8'd35, lto);
    chk("remote minus offset", 8'hFB, r1o);
    i_reg_host_model.wr_reg(8'h0E, 8'h0F);
    settle();
    chk("remote plus offset", 8'd25, r1o);
    $display("offset test done");
    @(posedge clk);
    alert_n <= 1'b0;
    settle();
    chk("alert ignored", 8'h00, {7'h00, full});
    i_reg_host_model.wr_reg(8'h3F, 8'h80);
    settle();
    chk("alert full speed", 8'h01, {7'h00, full});
    chk("alert duty", 8'h0F, {4'h0, ld});
    @(posedge clk);
    alert_n <= 1'b1;
    settle();
    chk("alert released", 8'h00, {7'h00, full});
    $display("alert test done");
    // every register but remote 1 start/span (0x25) was rewritten above, so a mid-run reset must restore them
    @(posedge clk);
    nrst_n <= 1'b0;
    repeat (2) @(posedge clk);
    nrst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      i_reg_host_model.rd_reg(ra[i], d);
      chk("second reset value", re[i], d);
    end
    chk("second reset full", 8'h00, {7'h00, full});
    $display("second reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
